/* File: bench/csp_core_bench.sv */
`default_nettype none
module csp_core_bench
	import csp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic clk, sys_rst, core_rst, avs_read, avs_write, avs_waitrequest, op_valid, op_ready;
	logic [5:0] avs_address;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata, seed, q;
	csp_alu_e op_alu;
	csp_branch_e op_branch;
	logic [7:0] op_a, op_b, core_flags, indirect_pointer, pc_high_latch, w_data;
	logic [7:0] mem_addr, mem_wdata, mem_rdata;
	logic op_to_file, sleep_exec, wdt_clear, wdt_timeout, irq_take, push_valid, w_we, mem_we;
	logic [6:0] op_file;
	logic [10:0] op_target;
	logic [12:0] pop_addr, push_addr, pc, m_pc;
	logic [7:0] m_f, m_ptr;
	logic [4:0] m_lat;
	logic [7:0] dmem [256];
	int fail_count, n_tests;

	csp_core uut (.clk(clk), .sys_rst(sys_rst), .core_rst(core_rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .op_valid(op_valid), .op_ready(op_ready),
		.op_alu(op_alu), .op_a(op_a), .op_b(op_b), .op_to_file(op_to_file), .op_file(op_file),
		.op_branch(op_branch), .op_target(op_target), .pop_addr(pop_addr),
		.sleep_exec(sleep_exec), .wdt_clear(wdt_clear), .wdt_timeout(wdt_timeout),
		.irq_take(irq_take), .push_valid(push_valid), .push_addr(push_addr), .pc(pc),
		.core_flags(core_flags), .indirect_pointer(indirect_pointer),
		.pc_high_latch(pc_high_latch), .w_data(w_data), .w_we(w_we), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_we(mem_we), .mem_rdata(mem_rdata));

	// Data memory stand-in; seeded so indirect reads never see unknowns
	assign mem_rdata = dmem[mem_addr];
	always @(posedge clk) begin
		if (mem_we === 1'b1)
			dmem[mem_addr] <= mem_wdata;
	end

	initial begin
		clk = 0;
		forever #20 clk = !clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : print_verdict

	task automatic bus(input logic wr, input logic [3:0] idx, input logic [7:0] d, input logic be);
		@(posedge clk);
		avs_address <= {idx, 2'b00};
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= {rnd() & 32'hffffff00} | {24'h0, d};
		avs_byteenable <= {3'b111, be};
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 0;
		avs_write <= 0;
		if (wr && be) begin
			case (idx)
				4'h2: m_pc = {m_lat, d};
				4'h3: m_f = (d & 8'he7) | (m_f & 8'h18);
				4'h4: m_ptr = d;
				4'ha: m_lat = d[4:0];
				default: ;
			endcase
		end
	endtask : bus

	task automatic state();
		#1;
		chk(pc, m_pc);
		chk(core_flags, m_f);
		chk(pc_high_latch, {3'h0, m_lat});
		chk(indirect_pointer, m_ptr);
	endtask : state

	task automatic regs();
		bus(0, 4'h2, 8'h00, 1); chk(q, {24'h0, m_pc[7:0]});
		bus(0, 4'h3, 8'h00, 1); chk(q, {24'h0, m_f});
		bus(0, 4'ha, 8'h00, 1); chk(q, {27'h0, m_lat});
		bus(0, 4'h4, 8'h00, 1); chk(q, {24'h0, m_ptr});
		bus(0, 4'h0, 8'h00, 1); chk(q, {24'h0, dmem[m_ptr]});
		bus(0, 4'h1, 8'h00, 1); chk(q, 32'h0);
	endtask : regs

	////////////////////////////////////////////////////////////////////////////////
	task automatic op();
		logic [31:0] r, r2;
		logic [7:0] a, b, res, nf;
		logic [6:0] file;
		logic [2:0] aff;
		logic tof, irq, slp, clr, tmo, c, dc, ew, em, ep;
		logic [12:0] pa;
		csp_alu_e alu;
		csp_branch_e br;
		r = rnd();
		r2 = rnd();
		alu = csp_alu_e'(r[3:0] % 4'd9);
		a = r[11:4];
		b = r[19:12];
		case (r[22:20])
			3'd0: file = 7'h00;
			3'd1: file = 7'h02;
			3'd2: file = 7'h03;
			3'd3: file = 7'h04;
			3'd4: file = 7'h0a;
			default: file = {1'b1, r[28:23]};
		endcase
		irq = r2[3:0] == 4'h0;
		slp = r2[7:4] == 4'h1;
		clr = r2[7:4] == 4'h2;
		tmo = r2[11:8] == 4'h0;
		tof = r[29] && !slp && !clr;
		br = tof ? BR_NONE : csp_branch_e'(r[31:30]);
		c = m_f[0];
		dc = m_f[1];
		aff = 3'b000;
		res = a;
		case (alu)
			ALU_PASS: ;
			ALU_PASS_Z: aff = 3'b100;
			ALU_ADD: begin
				{c, res} = a + b;
				dc = (a[3:0] + b[3:0]) > 15;
				aff = 3'b111;
			end
			ALU_SUB: begin
				{c, res} = {1'b0, a} + {1'b0, ~b} + 9'h001;
				dc = a[3:0] >= b[3:0];
				aff = 3'b111;
			end
			ALU_AND: begin res = a & b; aff = 3'b100; end
			ALU_OR: begin res = a | b; aff = 3'b100; end
			ALU_XOR: begin res = a ^ b; aff = 3'b100; end
			ALU_RL: begin res = {a[6:0], m_f[0]}; c = a[7]; aff = 3'b001; end
			default: begin res = {m_f[0], a[7:1]}; c = a[0]; aff = 3'b001; end
		endcase
		// Reserved flag bits must stay clear, so such results go to the pointer instead
		if (tof && file == 7'h03 && res[7:6] != 2'b00)
			file = 7'h04;
		@(posedge clk);
		{op_alu, op_a, op_b, op_file, op_to_file, op_branch} <= {alu, a, b, file, tof, br};
		{op_target, pop_addr} <= {r2[22:12], r2[31:23], r2[3:0]};
		{sleep_exec, wdt_clear, wdt_timeout, irq_take, op_valid} <= {slp, clr, tmo, irq, 1'b1};
		@(posedge clk);
		chk(op_ready, 1);
		{sleep_exec, wdt_clear, wdt_timeout, irq_take, op_valid} <= 5'h00;
		nf = m_f;
		{ep, ew, em, pa} = {3'b000, m_pc + 13'h1};
		if (irq) begin
			{ep, pa, m_pc} = {1'b1, m_pc, 13'h0004};
		end else begin
			if (tof && file == 7'h03)
				nf = {res[7:5], m_f[4:3], res[2:0]};
			if (aff[2])
				nf[2] = res == 8'h00;
			if (aff[1])
				nf[1] = dc;
			if (aff[0])
				nf[0] = c;
			if (slp)
				nf[4:3] = 2'b10;
			if (clr)
				nf[4:3] = 2'b11;
			case (br)
				BR_NONE: m_pc = m_pc + 13'h1;
				BR_RETURN: m_pc = pop_addr;
				default: begin
					ep = br == BR_CALL;
					m_pc = {m_lat[4:3], r2[22:12]};
				end
			endcase
			ew = !tof;
			if (tof) begin
				case (file)
					7'h02: m_pc = {m_lat, res};
					7'h03: ;
					7'h04: m_ptr = res;
					7'h0a: m_lat = res[4:0];
					default: begin
						em = 1;
						a = file == 7'h00 ? m_ptr : {m_f[5], file};
					end
				endcase
			end
		end
		if (tmo)
			nf[4] = 0;
		m_f = nf;
		state();
		chk(push_valid, ep);
		if (ep)
			chk(push_addr, pa);
		chk(w_we, ew);
		if (ew)
			chk(w_data, res);
		chk(mem_we, em);
		if (em)
			chk({mem_addr, mem_wdata}, {a, res});
	endtask : op

	task automatic do_reset();
		@(posedge clk);
		sys_rst <= 1;
		repeat (3) @(posedge clk);
		sys_rst <= 0;
		{m_pc, m_f, m_ptr, m_lat} = {13'h0, 8'h18, 8'h00, 5'h00};
		state();
	endtask : do_reset

	initial begin
		#(40 * 20000);
		fail_count++;
		print_verdict();
	end

	initial begin
		seed = 32'h6c64;
		{core_rst, avs_read, avs_write, avs_address, avs_byteenable, avs_writedata} = '0;
		{op_valid, op_a, op_b, op_to_file, op_file, op_target, pop_addr} = '0;
		{op_alu, op_branch} = {ALU_PASS, BR_NONE};
		{sleep_exec, wdt_clear, wdt_timeout, irq_take} = '0;
		{fail_count, n_tests} = '0;
		for (int i = 0; i < 256; i++)
			dmem[i] = i[7:0] ^ 8'ha5;
		sys_rst = 1;
		repeat (3) @(posedge clk);
		sys_rst <= 0;
		{m_pc, m_f, m_ptr, m_lat} = {13'h0, 8'h18, 8'h00, 5'h00};
		regs();
		bus(1, 4'ha, 8'hff, 1);
		bus(1, 4'h4, 8'h5a, 1);
		bus(1, 4'h4, 8'h11, 0); // Lane 0 disabled, no effect
		bus(1, 4'h3, 8'h27, 1);
		bus(1, 4'h0, 8'h3c, 1);
		bus(1, 4'h1, 8'h77, 1);
		bus(1, 4'h2, 8'h34, 1);
		state();
		// Table entry past a low-byte rollover: latch bumped before the low-byte write
		bus(1, 4'ha, 8'h02, 1);
		bus(1, 4'h2, 8'h05, 1);
		state();
		bus(1, 4'ha, 8'hff, 1);
		bus(1, 4'h2, 8'h34, 1);
		state();
		regs();
		for (int i = 0; i < 400; i++) begin
			op();
			if (i % 80 == 79)
				regs();
		end
		@(posedge clk);
		core_rst <= 1;
		@(posedge clk);
		core_rst <= 0;
		{m_pc, m_lat, m_f[7:5]} = '0;
		state();
		for (int i = 0; i < 100; i++)
			op();
		do_reset();
		regs();
		print_verdict();
	end
endmodule : csp_core_bench
`default_nettype wire

/* File: design/csp_core.sv */
`include "csp_defines.svh"
`default_nettype none

// Notes on behaviour
// [R1] Flag-affecting ops to the flag register set Z, DC, C from the result.
// [R2] Watchdog-expiry and sleep-entered flags are never changed by writes.
// [R3] Bank select bit picks 80h-FFh when one, 00h-7Fh when zero.
// [R4] Watchdog flag set by power-up, watchdog clear, sleep; cleared by time-out.
// [R5] Sleep flag set by power-up or watchdog clear; cleared by sleep.
// [R6] Zero flag is one exactly when the result is zero.
// [R7] Add and subtract: DC is the carry out of result bit 3.
// [R8] Add and subtract: C is the carry out of the top result bit.
// [R9] Subtract adds the two's complement; C and DC read as inverted borrows.
// [R10] Rotates load C with the bit shifted out of the source.
// [R11] Counter is 13 bits; low byte readable and writable, top five hidden.
// [R12] Every reset clears the whole program counter.
// [R13] Writing the low byte loads the top five bits from the latch.
// [R14] Jump and call take 11 bits; latch bits 4:3 give the rest.
// [R15] Call and interrupt push the full 13-bit counter.
// [R16] The latch only holds the top bits; it never reads back the counter.
// [R17] Core registers answer at the same offset from either bank.
// [R18] Software keeps the two reserved bits above the bank bit at zero.
// [R19] Software bumps the latch for each low-byte rollover in tables.
// [R20] Software should alter the flag register only with non-flag ops.
// [R21] Loading, pushing or popping leaves the latch contents unchanged.
// [R22] The indirect port reaches memory at the pointer; no storage of its own.
module csp_core
	import csp_pkg::*;
(
	input wire logic clk, // 25 MHz instruction clock
	input wire logic sys_rst, // Power-on or brown-out reset
	input wire logic core_rst, // Other resets, one-cycle pulse
	input wire logic [5:0] avs_address, // Byte address
	input wire logic avs_read, // Read request
	input wire logic avs_write, // Write request
	input wire logic [3:0] avs_byteenable, // Lane 0 carries the register
	input wire logic [31:0] avs_writedata, // Write data
	output logic [31:0] avs_readdata, // Read data
	output logic avs_waitrequest, // Low in the answering cycle
	input wire logic op_valid, // Instruction ready to execute
	output logic op_ready, // Core accepts the instruction
	input wire csp_alu_e op_alu, // Operation
	input wire logic [7:0] op_a, // File or source operand
	input wire logic [7:0] op_b, // Second operand
	input wire logic op_to_file, // Result goes to a file register
	input wire logic [6:0] op_file, // Direct file address
	input wire csp_branch_e op_branch, // Flow change
	input wire logic [10:0] op_target, // In-page target
	input wire logic [12:0] pop_addr, // Return address from the stack
	input wire logic sleep_exec, // Instruction is sleep
	input wire logic wdt_clear, // Instruction is watchdog clear
	input wire logic wdt_timeout, // Watchdog expired, pulse
	input wire logic irq_take, // Take interrupt instead of the op
	output logic push_valid, // Push a return address
	output logic [12:0] push_addr, // Address pushed
	output logic [12:0] pc, // Program counter
	output logic [7:0] core_flags, // Flag register
	output logic [7:0] indirect_pointer, // Indirect pointer
	output logic [7:0] pc_high_latch, // High latch, top bits zero
	output logic [7:0] w_data, // Result bound for the work register
	output logic w_we, // Work register write
	output logic [7:0] mem_addr, // Data memory address
	output logic [7:0] mem_wdata, // Data memory write data
	output logic mem_we, // Data memory write
	input wire logic [7:0] mem_rdata // Data memory read, same cycle
);

	////////////////////////////////////////////////////////////////////
	csp_bus_e state, next_state;
	logic [31:0] next_readdata;
	logic [3:0] idx;
	logic req, bus_we;
	logic exec, irq_go;
	logic [7:0] alu_res;
	logic [8:0] sum9;
	logic [4:0] sum4;
	logic aff_z, aff_dc, aff_c, res_c, res_dc;
	logic file_core;
	logic [12:0] next_pc, next_push_addr;
	logic next_push_valid;
	logic [7:0] next_flags, next_pointer;
	logic [4:0] latch, next_latch;
	logic [7:0] next_w_data, next_mem_addr, next_mem_wdata;
	logic next_w_we, next_mem_we;

	assign idx = avs_address[5:2];
	assign req = avs_read | avs_write;
	// Bus takes the core for three cycles; instructions wait meanwhile
	assign op_ready = (state == BUS_IDLE) && !req;
	assign avs_waitrequest = (state != BUS_ANSWER);
	assign bus_we = (state == BUS_ANSWER) && avs_write && avs_byteenable[0];
	assign irq_go = irq_take && op_ready;
	assign exec = op_valid && op_ready && !irq_go;
	assign pc_high_latch = {3'h0, latch}; // R16
	// Core registers decoded on the file field alone, so both banks see them
	assign file_core = (op_file == `CSP_FILE_INDIRECT) || (op_file == `CSP_FILE_PCL) ||
		(op_file == `CSP_FILE_FLAGS) || (op_file == `CSP_FILE_POINTER) ||
		(op_file == `CSP_FILE_LATCH); // R17

	////////////////////////////////////////////////////////////////////
	always_comb begin
		sum9 = 9'h000;
		sum4 = 5'h00;
		alu_res = op_a;
		aff_z = 1'b0;
		aff_dc = 1'b0;
		aff_c = 1'b0;
		res_c = 1'b0;
		res_dc = 1'b0;
		case (op_alu)
			ALU_PASS: begin
				alu_res = op_a;
			end
			ALU_PASS_Z: begin
				aff_z = 1'b1;
			end
			ALU_ADD, ALU_SUB: begin
				if (op_alu == ALU_ADD) begin
					sum9 = {1'b0, op_a} + {1'b0, op_b};
					sum4 = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]};
				end else begin
					// Borrow shows as an inverted carry
					sum9 = {1'b0, op_a} + {1'b0, ~op_b} + 9'h001; // R9
					sum4 = {1'b0, op_a[3:0]} + {1'b0, ~op_b[3:0]} + 5'h01; // R9
				end
				alu_res = sum9[7:0];
				res_c = sum9[8]; // R8
				res_dc = sum4[4]; // R7
				aff_z = 1'b1;
				aff_dc = 1'b1;
				aff_c = 1'b1;
			end
			ALU_AND: begin
				alu_res = op_a & op_b;
				aff_z = 1'b1;
			end
			ALU_OR: begin
				alu_res = op_a | op_b;
				aff_z = 1'b1;
			end
			ALU_XOR: begin
				alu_res = op_a ^ op_b;
				aff_z = 1'b1;
			end
			ALU_RL: begin
				alu_res = {op_a[6:0], core_flags[`CSP_BIT_C]};
				res_c = op_a[7]; // R10
				aff_c = 1'b1;
			end
			ALU_RR: begin
				alu_res = {core_flags[`CSP_BIT_C], op_a[7:1]};
				res_c = op_a[0]; // R10
				aff_c = 1'b1;
			end
			default: begin
				alu_res = op_a;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Flags, pointer and latch
	always_comb begin
		next_flags = core_flags;
		next_pointer = indirect_pointer;
		next_latch = latch;
		if (exec && op_to_file) begin
			case (op_file)
				`CSP_FILE_FLAGS: begin
					next_flags[7:5] = alu_res[7:5];
					next_flags[2:0] = alu_res[2:0];
				end
				`CSP_FILE_POINTER: next_pointer = alu_res;
				`CSP_FILE_LATCH: next_latch = alu_res[4:0];
				default: next_latch = latch; // R21
			endcase
		end
		// Arithmetic outcome overrides any write to the same bits
		if (exec && aff_z) begin
			next_flags[`CSP_BIT_Z] = (alu_res == 8'h00); // R1 R6
		end
		if (exec && aff_dc) begin
			next_flags[`CSP_BIT_DC] = res_dc; // R1 R7
		end
		if (exec && aff_c) begin
			next_flags[`CSP_BIT_C] = res_c; // R1 R8
		end
		if (bus_we) begin
			case (idx)
				`CSP_IDX_FLAGS: begin
					next_flags[7:5] = avs_writedata[7:5]; // R2
					next_flags[2:0] = avs_writedata[2:0]; // R2
				end
				`CSP_IDX_POINTER: next_pointer = avs_writedata[7:0];
				`CSP_IDX_LATCH: next_latch = avs_writedata[4:0];
				default: next_pointer = indirect_pointer;
			endcase
		end
		if (exec && wdt_clear) begin
			next_flags[`CSP_BIT_WDOG] = 1'b1; // R4
			next_flags[`CSP_BIT_SLEEP] = 1'b1; // R5
		end
		if (exec && sleep_exec) begin
			next_flags[`CSP_BIT_WDOG] = 1'b1; // R4
			next_flags[`CSP_BIT_SLEEP] = 1'b0; // R5
		end
		// Time-out is a hardware event and wins over a coincident clear
		if (wdt_timeout) begin
			next_flags[`CSP_BIT_WDOG] = 1'b0; // R4
		end
		if (core_rst) begin
			next_flags[7:5] = 3'h0;
			next_latch = `CSP_LATCH_RESET;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Program counter and stack push
	always_comb begin
		next_pc = pc;
		next_push_valid = 1'b0;
		next_push_addr = push_addr;
		if (core_rst) begin
			next_pc = `CSP_PC_RESET; // R12
		end else if (irq_go) begin
			next_push_valid = 1'b1;
			next_push_addr = pc; // R15
			next_pc = `CSP_IRQ_VECTOR;
		end else if (exec) begin
			case (op_branch)
				BR_JUMP: next_pc = {latch[4:3], op_target}; // R14
				BR_CALL: begin
					next_push_valid = 1'b1;
					next_push_addr = pc + 13'h0001; // R15
					next_pc = {latch[4:3], op_target}; // R14
				end
				BR_RETURN: next_pc = pop_addr; // R21
				default: begin
					if (op_to_file && (op_file == `CSP_FILE_PCL)) begin
						next_pc = {latch, alu_res}; // R13
					end else begin
						next_pc = pc + 13'h0001;
					end
				end
			endcase
		end else if (bus_we && (idx == `CSP_IDX_PCL)) begin
			next_pc = {latch, avs_writedata[7:0]}; // R11 R13
		end
	end

	////////////////////////////////////////////////////////////////////
	// Data memory, work register and bus sequencing
	always_comb begin
		next_state = state;
		next_readdata = avs_readdata;
		next_mem_addr = mem_addr;
		next_mem_wdata = mem_wdata;
		next_mem_we = 1'b0;
		next_w_data = alu_res;
		next_w_we = exec && !op_to_file;
		if (exec && op_to_file && (op_file == `CSP_FILE_INDIRECT)) begin
			next_mem_addr = indirect_pointer; // R22
			next_mem_wdata = alu_res;
			next_mem_we = 1'b1;
		end else if (exec && op_to_file && !file_core) begin
			next_mem_addr = {core_flags[`CSP_BIT_BANK], op_file}; // R3
			next_mem_wdata = alu_res;
			next_mem_we = 1'b1;
		end
		case (state)
			BUS_IDLE: begin
				if (req) begin
					next_mem_addr = indirect_pointer; // R22
					next_state = BUS_FETCH;
				end
			end
			BUS_FETCH: begin
				case (idx)
					`CSP_IDX_INDIRECT: next_readdata = {24'h000000, mem_rdata}; // R22
					`CSP_IDX_PCL: next_readdata = {24'h000000, pc[7:0]}; // R11
					`CSP_IDX_FLAGS: next_readdata = {24'h000000, core_flags};
					`CSP_IDX_POINTER: next_readdata = {24'h000000, indirect_pointer};
					`CSP_IDX_LATCH: next_readdata = {24'h000000, pc_high_latch};
					default: next_readdata = 32'h00000000;
				endcase
				next_state = BUS_ANSWER;
			end
			BUS_ANSWER: begin
				if (bus_we && (idx == `CSP_IDX_INDIRECT)) begin
					next_mem_addr = indirect_pointer; // R22
					next_mem_wdata = avs_writedata[7:0];
					next_mem_we = 1'b1;
				end
				next_state = BUS_IDLE;
			end
			default: next_state = BUS_IDLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state <= BUS_IDLE;
			avs_readdata <= 32'h00000000;
			pc <= `CSP_PC_RESET; // R12
			push_valid <= 1'b0;
			push_addr <= `CSP_PC_RESET;
			core_flags <= `CSP_FLAGS_POR; // R4 R5
			indirect_pointer <= `CSP_POINTER_RESET;
			latch <= `CSP_LATCH_RESET;
			w_data <= 8'h00;
			w_we <= 1'b0;
			mem_addr <= 8'h00;
			mem_wdata <= 8'h00;
			mem_we <= 1'b0;
		end else begin
			state <= next_state;
			avs_readdata <= next_readdata;
			pc <= next_pc;
			push_valid <= next_push_valid;
			push_addr <= next_push_addr;
			core_flags <= next_flags;
			indirect_pointer <= next_pointer;
			latch <= next_latch;
			w_data <= next_w_data;
			w_we <= next_w_we;
			mem_addr <= next_mem_addr;
			mem_wdata <= next_mem_wdata;
			mem_we <= next_mem_we;
		end
	end

	////////////////////////////////////////////////////////////////////
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	zero_flag_a: assert property ((exec && aff_z && !core_rst) |=> // R6
		(core_flags[`CSP_BIT_Z] == ($past(alu_res) == 8'h00)))
		else $error("zero flag does not match result");
	add_carry_a: assert property ((exec && op_alu == ALU_ADD) |=> // R8
		(core_flags[`CSP_BIT_C] == (({1'b0, $past(op_a)} + {1'b0, $past(op_b)}) > 9'h0ff)))
		else $error("carry wrong after add");
	add_nibble_a: assert property ((exec && op_alu == ALU_ADD) |=> // R7
		(core_flags[`CSP_BIT_DC] ==
		(({1'b0, $past(op_a[3:0])} + {1'b0, $past(op_b[3:0])}) > 5'h0f)))
		else $error("digit carry wrong after add");
	sub_borrow_a: assert property ((exec && op_alu == ALU_SUB) |=> // R9
		(core_flags[`CSP_BIT_C] == ($past(op_a) >= $past(op_b))) &&
		(core_flags[`CSP_BIT_DC] == ($past(op_a[3:0]) >= $past(op_b[3:0]))))
		else $error("borrow polarity wrong after subtract");
	rotate_carry_a: assert property ((exec && op_alu == ALU_RL) |=> // R10
		(core_flags[`CSP_BIT_C] == $past(op_a[7])))
		else $error("rotate left did not load carry");
	flags_readonly_a: assert property ((bus_we && idx == `CSP_IDX_FLAGS && !wdt_timeout) |=> // R2
		(core_flags[4:3] == $past(core_flags[4:3])))
		else $error("write changed read-only flags");
	sleep_flags_a: assert property ((exec && sleep_exec && !wdt_clear && !wdt_timeout) |=> // R5
		(!core_flags[`CSP_BIT_SLEEP] && core_flags[`CSP_BIT_WDOG]))
		else $error("sleep did not set flags");
	pcl_load_a: assert property ((exec && op_to_file && op_file == `CSP_FILE_PCL && // R13
		op_branch == BR_NONE && !core_rst) |=>
		(pc == {$past(pc_high_latch[4:0]), $past(alu_res)}))
		else $error("low-byte write did not load latch bits");
	jump_page_a: assert property ((exec && op_branch == BR_JUMP && !core_rst) |=> // R14
		(pc[12:11] == $past(latch[4:3])) && (pc[10:0] == $past(op_target)))
		else $error("jump target or page wrong");
	call_push_a: assert property ((exec && op_branch == BR_CALL && !core_rst) |=> // R15
		push_valid && (push_addr == $past(pc) + 13'h0001))
		else $error("call did not push return address");
	pc_reset_a: assert property (core_rst |=> (pc == `CSP_PC_RESET) && !push_valid) // R12
		else $error("reset did not clear counter");
	bank_addr_a: assert property ((exec && op_to_file && !file_core) |=> // R3
		mem_we && (mem_addr == {$past(core_flags[`CSP_BIT_BANK]), $past(op_file)}))
		else $error("direct address ignores bank bit");
	latch_hold_a: assert property ((!core_rst && !(exec && op_to_file && op_file == `CSP_FILE_LATCH) &&
		!(bus_we && idx == `CSP_IDX_LATCH)) |=> $stable(pc_high_latch)) // R21
		else $error("latch changed without a write");
	bus_answer_a: assert property ((state == BUS_IDLE && req) |-> // R22
		avs_waitrequest ##1 avs_waitrequest ##1 !avs_waitrequest)
		else $error("bus answer not on third cycle");

endmodule : csp_core

`default_nettype wire

/* File: design/csp_defines.svh */
`ifndef CSP_DEFINES_SVH
`define CSP_DEFINES_SVH

// Register indexes on the bus; byte address is four times the index
`define CSP_IDX_INDIRECT 4'h0
`define CSP_IDX_PCL 4'h2
`define CSP_IDX_FLAGS 4'h3
`define CSP_IDX_POINTER 4'h4
`define CSP_IDX_LATCH 4'ha

// Same registers as seen by an instruction's 7-bit file field
`define CSP_FILE_INDIRECT 7'h00
`define CSP_FILE_PCL 7'h02
`define CSP_FILE_FLAGS 7'h03
`define CSP_FILE_POINTER 7'h04
`define CSP_FILE_LATCH 7'h0a

// Field positions in core_flags
`define CSP_BIT_C 0
`define CSP_BIT_DC 1
`define CSP_BIT_Z 2
`define CSP_BIT_SLEEP 3
`define CSP_BIT_WDOG 4
`define CSP_BIT_BANK 5

// Reset values and interrupt vector
`define CSP_FLAGS_POR 8'h18
`define CSP_PC_RESET 13'h0000
`define CSP_LATCH_RESET 5'h00
`define CSP_POINTER_RESET 8'h00
`define CSP_IRQ_VECTOR 13'h0004

`endif

/* File: design/csp_pkg.sv */
`default_nettype none

package csp_pkg;

	typedef enum logic [3:0] {
		ALU_PASS,
		ALU_PASS_Z,
		ALU_ADD,
		ALU_SUB,
		ALU_AND,
		ALU_OR,
		ALU_XOR,
		ALU_RL,
		ALU_RR
	} csp_alu_e;

	typedef enum logic [1:0] {BR_NONE, BR_JUMP, BR_CALL, BR_RETURN} csp_branch_e;

	typedef enum logic [1:0] {BUS_IDLE, BUS_FETCH, BUS_ANSWER} csp_bus_e;

endpackage : csp_pkg

`default_nettype wire
